// >>> hdl/adsc_pkg.sv
package adsc_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CHSEL = 8'h04;
   localparam logic [7:0] ADDR_TIMING = 8'h08;
   localparam logic [7:0] ADDR_RESULT = 8'h0C;
   localparam logic [7:0] ADDR_INJ = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
   localparam logic [7:0] ADDR_DIGIN = 8'h20;
   // control register fields
   localparam int CTRL_START = 0;
   localparam int CTRL_CONT = 1;
   localparam int CTRL_SCAN = 2;
   localparam int CTRL_WAITRD = 3;
   localparam int CTRL_PORTSEL = 4;
   localparam int CTRL_INJ = 5;
   localparam int CTRL_STOP = 6;
   localparam int CTRL_CH_LSB = 8;
   localparam int CTRL_INJCH_LSB = 16;
   // status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_CAL = 1;
   localparam int STAT_HOLD = 2;
   localparam int STAT_INJ = 3;
   // interrupt status bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OVR = 1;
   localparam int IRQ_INJ = 2;
   localparam int IRQ_W = 3;
   // converter geometry
   localparam int RES_W = 10;
   localparam int CH_W = 5;
   localparam int NCH = 24;
   localparam int GRP_W = 16;
   // timing; the block clock is the cpu clock, so calibration counts it directly
   localparam int CAL_CPU_CYCLES = 40630;
   localparam int CAL_CYCLES = CAL_CPU_CYCLES;
   localparam logic [31:0] TIMING_RESET = 32'h0010_0008;
   // writable bits; start, inject and stop are strobes and read back as zero
   localparam logic [31:0] CTRL_WMASK = 32'h001F_1F1E;
   localparam logic [31:0] CHSEL_WMASK = 32'h00FF_FFFF;
   localparam logic [31:0] CHSEL_RESET = 32'h0000_0001;
   typedef enum logic [4:0] {
      ADSC_CAL = 5'h01,
      ADSC_IDLE = 5'h02,
      ADSC_SAMPLE = 5'h04,
      ADSC_CONV = 5'h08,
      ADSC_HOLD = 5'h10
   } adsc_state_t;
endpackage

// >>> hdl/adsc_top.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module adsc_top #(
   parameter int CAL_LEN = adsc_pkg::CAL_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic [adsc_pkg::CH_W-1:0] mux_sel,
   output logic mux_group,
   output logic sample_en,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [adsc_pkg::RES_W-1:0] conv_data,
   input wire logic [adsc_pkg::GRP_W-1:0] group0_digital,
   input wire logic [adsc_pkg::GRP_W-1:0] group1_digital,
   output logic cal_run
);
   import adsc_pkg::*;

   adsc_state_t state;
   logic [31:0] ctrl;
   logic [31:0] chsel;
   logic [31:0] timing;
   logic [RES_W-1:0] result;
   logic [CH_W-1:0] result_ch;
   logic result_full;
   logic [RES_W-1:0] temp_buf;
   logic [CH_W-1:0] temp_ch;
   logic [RES_W-1:0] inj_result;
   logic inj_pend;
   logic inj_active;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [31:0] cal_cnt;
   logic [15:0] tcnt;
   logic [CH_W-1:0] cur_ch;
   logic wr_acc;
   logic rd_acc;
   logic result_read;
   logic stat_read;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_keep;
   logic conv_fin;
   logic [CH_W-1:0] next_ch;
   logic [CH_W-1:0] first_ch;
   logic scan_wrap;
   logic [31:0] next_rdata;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign result_read = rd_acc & (paddr == ADDR_RESULT);
   assign stat_read = rd_acc & (paddr == ADDR_IRQ_STAT);
   assign conv_fin = (state == ADSC_CONV) & conv_done;

   // next selected channel above the current one, wrapping to lowest
   always_comb begin
      first_ch = '0;
      next_ch = '0;
      scan_wrap = 1'b1;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (chsel[i]) begin
            first_ch = CH_W'(i);
         end
         if (chsel[i] && (i > int'(cur_ch))) begin
            next_ch = CH_W'(i);
            scan_wrap = 1'b0;
         end
      end
      if (scan_wrap) begin
         next_ch = first_ch;
      end
   end

   // calibration counter runs once after reset, never again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_cnt <= 32'h0000_0000;
      end else if (state == ADSC_CAL) begin
         cal_cnt <= cal_cnt + 32'h0000_0001;
      end
   end

   // conversion sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ADSC_CAL;
         tcnt <= 16'h0000;
         cur_ch <= '0;
         inj_active <= 1'b0;
      end else begin
         unique case (state)
            ADSC_CAL: begin
               if (cal_cnt >= 32'(CAL_LEN - 1)) begin
                  state <= ADSC_IDLE;
               end
            end
            ADSC_IDLE: begin
               // a start is ignored until calibration is over
               if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_START]) begin
                  state <= ADSC_SAMPLE;
                  tcnt <= 16'h0000;
                  // a scan begins at the lowest selected channel
                  cur_ch <= pwdata[CTRL_SCAN] ? first_ch : pwdata[CTRL_CH_LSB +: CH_W];
               end
            end
            ADSC_SAMPLE: begin
               // sample window length programmable
               if (tcnt >= timing[15:0]) begin
                  state <= ADSC_CONV;
                  tcnt <= 16'h0000;
               end else begin
                  tcnt <= tcnt + 16'h0001;
               end
            end
            ADSC_CONV: begin
               if (conv_done && tcnt >= timing[31:16]) begin
                  tcnt <= 16'h0000;
                  if (inj_active) begin
                     inj_active <= 1'b0; // back to the running mode
                     state <= ADSC_SAMPLE;
                  end else if (ctrl[CTRL_CONT] && ctrl[CTRL_WAITRD] && result_full
                               && !result_read) begin
                     state <= ADSC_HOLD;
                  end else begin
                     state <= ADSC_IDLE;
                     if (ctrl[CTRL_SCAN]) begin
                        cur_ch <= next_ch;
                        if (ctrl[CTRL_CONT] || !scan_wrap) begin
                           state <= ADSC_SAMPLE;
                        end
                     end else if (ctrl[CTRL_CONT]) begin
                        state <= ADSC_SAMPLE;
                     end
                     if (ctrl[CTRL_CONT] && inj_pend) begin
                        inj_active <= 1'b1;
                        state <= ADSC_SAMPLE;
                     end
                  end
               end else if (tcnt != 16'hFFFF) begin
                  tcnt <= tcnt + 16'h0001;
               end
            end
            ADSC_HOLD: begin
               // released once software reads the result
               if (result_read) begin
                  state <= ADSC_IDLE;
                  if (ctrl[CTRL_SCAN]) begin
                     cur_ch <= next_ch;
                  end
                  if (ctrl[CTRL_CONT]) begin
                     state <= ADSC_SAMPLE;
                  end
               end
            end
            default: state <= ADSC_IDLE;
         endcase
         if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_STOP] && state != ADSC_CAL) begin
            state <= ADSC_IDLE;
            inj_active <= 1'b0;
         end
      end
   end

   // analog front-end drive: one channel at a time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_sel <= '0;
         mux_group <= 1'b0;
         sample_en <= 1'b0;
         conv_start <= 1'b0;
         cal_run <= 1'b1;
      end else begin
         mux_sel <= inj_active ? ctrl[CTRL_INJCH_LSB +: CH_W] : cur_ch;
         mux_group <= ctrl[CTRL_PORTSEL];
         sample_en <= (state == ADSC_SAMPLE);
         conv_start <= (state == ADSC_SAMPLE) && (tcnt >= timing[15:0]);
         cal_run <= (state == ADSC_CAL);
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 32'h0000_0000;
         chsel <= CHSEL_RESET;
         timing <= TIMING_RESET;
         irq_mask <= '0;
      end else if (wr_acc) begin
         unique case (paddr)
            ADDR_CTRL: ctrl <= pwdata & CTRL_WMASK; // strobes self-clear
            ADDR_CHSEL: chsel <= pwdata & CHSEL_WMASK;
            ADDR_TIMING: timing <= pwdata;
            ADDR_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // injection request, latched until its conversion starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inj_pend <= 1'b0;
      end else if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_INJ]) begin
         inj_pend <= 1'b1;
      end else if (inj_active) begin
         inj_pend <= 1'b0;
      end
   end

   // result registers; temp buffer holds a new value during wait-for-read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= '0;
         result_ch <= '0;
         result_full <= 1'b0;
         temp_buf <= '0;
         temp_ch <= '0;
         inj_result <= '0;
      end else begin
         if (conv_fin && tcnt >= timing[31:16] && inj_active) begin
            inj_result <= conv_data;
         end else if (conv_fin && tcnt >= timing[31:16] && state != ADSC_HOLD) begin
            if (ctrl[CTRL_CONT] && ctrl[CTRL_WAITRD] && result_full && !result_read) begin
               temp_buf <= conv_data;
               temp_ch <= cur_ch;
            end else begin
               result <= conv_data;
               result_ch <= cur_ch;
               result_full <= 1'b1;
            end
         end else if (state == ADSC_HOLD && result_read) begin
            result <= temp_buf;
            result_ch <= temp_ch;
            result_full <= 1'b1;
         end else if (result_read) begin
            result_full <= 1'b0;
         end
      end
   end

   // interrupt events; set wins over read-clear
   always_comb begin
      irq_set = '0;
      if (conv_fin && tcnt >= timing[31:16]) begin
         if (inj_active) begin
            irq_set[IRQ_INJ] = 1'b1;
         end else begin
            irq_set[IRQ_DONE] = 1'b1;
            if (result_full && !result_read && !ctrl[CTRL_WAITRD]) begin
               irq_set[IRQ_OVR] = 1'b1;
            end
         end
      end
   end

   // a read clears only the bits it returned, so an event that lands in the
   // setup cycle is kept for the next read instead of being lost
   assign irq_keep = stat_read ? (irq_stat & ~prdata[IRQ_W-1:0]) : irq_stat;

   // sticky status and level interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat <= irq_keep | irq_set;
         irq <= |((irq_keep | irq_set) & irq_mask);
      end
   end

   // read mux; digital view of channel pins stays live
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: next_rdata = ctrl;
         ADDR_CHSEL: next_rdata = chsel;
         ADDR_TIMING: next_rdata = timing;
         ADDR_RESULT: next_rdata = {11'h000, result_ch, 6'h00, result};
         ADDR_INJ: next_rdata = {22'h000000, inj_result};
         ADDR_STATUS: next_rdata = {28'h0000000, inj_active, state == ADSC_HOLD,
                                    state == ADSC_CAL, state != ADSC_IDLE};
         ADDR_IRQ_STAT: next_rdata = {29'h00000000, irq_stat};
         ADDR_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
         ADDR_DIGIN: next_rdata = {group1_digital, group0_digital};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // apb slave: zero-wait, registered answer in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > ADDR_DIGIN || paddr[1:0] != 2'b00);
         prdata <= next_rdata;
      end
   end

   property busy_cal_p;
      @(posedge pclk) disable iff (!presetn)
         (state == ADSC_CAL) |-> ##1 cal_run;
   endproperty
   busy_during_cal_a: assert property (busy_cal_p)
      else $error("busy output low during calibration");
   no_conv_cal_a: assert property (@(posedge pclk) disable iff (!presetn)
      cal_run |-> !sample_en && !conv_start)
      else $error("conversion during calibration");
   cal_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      cal_cnt <= 32'(CAL_LEN))
      else $error("calibration overran");
   cal_once_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state != ADSC_CAL) |=> (state != ADSC_CAL))
      else $error("calibration repeated");
   // a conversion end that the sequencer accepts
   sequence conv_end_s;
      conv_fin && tcnt >= timing[31:16];
   endsequence
   ovr_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_end_s ##0 (!inj_active && result_full && !result_read && !ctrl[CTRL_WAITRD]))
      |=> irq_stat[IRQ_OVR])
      else $error("overrun not flagged");
   done_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_end_s ##0 !inj_active) |=> irq_stat[IRQ_DONE])
      else $error("result request not raised");
   inj_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      (conv_end_s ##0 inj_active) |=> inj_result == $past(conv_data))
      else $error("injected result not stored");
   hold_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == ADSC_HOLD && !result_read) |=> state == ADSC_HOLD || $past(wr_acc))
      else $error("hold left without read");
   start_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      ($past(state) == ADSC_IDLE && state == ADSC_SAMPLE) |-> $past(wr_acc))
      else $error("sampling without start");
   group_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 mux_group == $past(ctrl[CTRL_PORTSEL]))
      else $error("port group not following control");
endmodule

// >>> tb/adsc_conv_model.sv
`timescale 1ns/1ps
// behavioural converter behind the analog mux; answers after a short or long delay
module adsc_conv_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic conv_start,
   input wire logic sample_en,
   input wire logic mux_group,
   input wire logic [4:0] mux_sel,
   output logic conv_done,
   output logic [9:0] conv_data
);
   logic [3:0] cnt;
   logic busy;
   // data toggles while not valid so a stale sample never looks like a result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         busy <= 1'b0;
         conv_done <= 1'b0;
         conv_data <= 10'h3FF;
      end else if (conv_start) begin
         busy <= 1'b1;
         cnt <= slow ? 4'h6 : 4'h1;
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         conv_data <= ~conv_data;
      end else if (busy) begin
         busy <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= {mux_group, mux_sel, 4'h5};
      end else if (sample_en) begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data;
      end
   end
endmodule

// >>> tb/test_adsc_top.sv
`timescale 1ns/1ps
module test_adsc_top;
   import adsc_pkg::*;
   localparam int CL = 20;
   localparam logic [31:0] ST = 32'h1 << CTRL_START;
   localparam logic [31:0] CO = 32'h1 << CTRL_CONT;
   localparam logic [31:0] SC = 32'h1 << CTRL_SCAN;
   localparam logic [31:0] RM = 32'h001F_03FF;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow;
   logic mux_group, sample_en, conv_start, conv_done, cal_run;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_val;
   logic [4:0] mux_sel, ch;
   logic [9:0] conv_data;
   logic [15:0] g0, g1;
   logic [31:0] q_exp[$], q_msk[$];
   logic q_err[$];
   int n_fail, tests_run, seed, nconv, n7, swid, last_sw, ccnt, cal_bad, n0, g;

   adsc_top #(.CAL_LEN(CL)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .mux_sel(mux_sel),
      .mux_group(mux_group), .sample_en(sample_en), .conv_start(conv_start),
      .conv_done(conv_done), .conv_data(conv_data), .group0_digital(g0),
      .group1_digital(g1), .cal_run(cal_run));
   adsc_conv_model conv_u (.pclk(pclk), .presetn(presetn), .slow(slow),
      .conv_start(conv_start), .sample_en(sample_en), .mux_group(mux_group),
      .mux_sel(mux_sel), .conv_done(conv_done), .conv_data(conv_data));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic tmo(input logic ok);
      if (!ok) begin
         n_fail++;
         $display("mismatch wait expected done seen timeout");
         print_verdict();
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd_val = prdata;
      tmo(i < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   // read noting the expected data under a mask for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic er);
      q_exp.push_back(e);
      q_msk.push_back(m);
      q_err.push_back(er);
      xfer(1'b0, a, 32'h0);
   endtask

   task automatic poll(input logic [7:0] a, input int b, input logic v);
      int i;
      for (i = 0; i < 300; i++) begin
         rd(a, 32'h0, 32'h0, 1'b0);
         if (rd_val[b] === v) break;
      end
      tmo(i < 300);
   endtask

   task automatic wait_irq;
      int i;
      for (i = 0; i < 500 && irq !== 1'b1; i++) @(posedge pclk);
      tmo(i < 500);
   endtask

   function automatic logic [31:0] res(input logic gp, input logic [4:0] c);
      return {11'h0, c, 6'h0, gp, c, 4'h5};
   endfunction

   // monitor: takes the oldest note at each read answer; counters use nba to avoid races
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && q_exp.size() > 0) begin
         chk("prdata", prdata & q_msk[0], q_exp[0] & q_msk[0]);
         chk("pslverr", {31'h0, pslverr}, {31'h0, q_err[0]});
         void'(q_exp.pop_front());
         void'(q_msk.pop_front());
         void'(q_err.pop_front());
      end
      if (sample_en) swid <= swid + 1;
      else if (swid != 0) begin
         last_sw <= swid;
         swid <= 0;
      end
      if (conv_start) nconv <= nconv + 1;
      if (conv_start && mux_sel == 5'h07) n7 <= n7 + 1;
      if (cal_run && presetn) ccnt <= ccnt + 1;
      if (cal_run && (sample_en || conv_start)) cal_bad <= 1;
   end

   initial begin
      repeat (100000) @(posedge pclk);
      tmo(1'b0);
   end

   initial begin
      seed = 60;
      {presetn, psel, penable, pwrite, slow} = 5'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      g0 = 16'h0;
      g1 = 16'h0;
      repeat (2) @(posedge pclk);
      chk("cal_run", {31'h0, cal_run}, 32'h1);
      presetn <= 1'b1;
      @(posedge pclk);
      wr(ADDR_CTRL, ST);
      rd(ADDR_STATUS, 32'h2, 32'h2, 1'b0);
      rd(ADDR_TIMING, TIMING_RESET, 32'hFFFF_FFFF, 1'b0);
      poll(ADDR_STATUS, STAT_CAL, 1'b0);
      chk("cal_conv", cal_bad, 0);
      chk("cal_len", {31'h0, ccnt <= CL + 2}, 32'h1);
      wr(ADDR_TIMING, 32'h0002_0003);
      rd(ADDR_TIMING, 32'h0002_0003, 32'hFFFF_FFFF, 1'b0);
      chk("no_early_start", swid + nconv, 0);
      // single shot on each port group, random channel
      for (g = 0; g < 2; g++) begin
         ch = 5'($unsigned($random(seed)) % 16);
         n0 = nconv;
         wr(ADDR_CTRL, ST | (32'(g) << CTRL_PORTSEL) | (32'(ch) << CTRL_CH_LSB));
         poll(ADDR_STATUS, STAT_BUSY, 1'b0);
         rd(ADDR_RESULT, res(g[0], ch), RM, 1'b0);
         chk("group", {31'h0, mux_group}, 32'(g));
         // the window spans the programmed count plus the cycle that launches conversion
         chk("sample_len", last_sw, 3 + 1);
         chk("conv_count", nconv - n0, 1);
      end
      // continuous, result never read: overrun
      wr(ADDR_IRQ_MASK, 32'h2);
      rd(ADDR_IRQ_STAT, 32'h0, 32'h0, 1'b0);
      n0 = nconv;
      wr(ADDR_CTRL, ST | CO | (32'h1 << CTRL_CH_LSB));
      wait_irq();
      poll(ADDR_STATUS, STAT_BUSY, 1'b1);
      wr(ADDR_CTRL, 32'h1 << CTRL_STOP);
      poll(ADDR_STATUS, STAT_BUSY, 1'b0);
      chk("cont_count", {31'h0, nconv - n0 >= 2}, 32'h1);
      rd(ADDR_RESULT, res(1'b0, 5'h01), RM, 1'b0);
      rd(ADDR_IRQ_STAT, 32'h2, 32'h2, 1'b0);
      repeat (2) @(posedge pclk);
      chk("irq_clear", {31'h0, irq}, 32'h0);
      // wait-for-read with a slow converter: conversion parks until read
      slow <= 1'b1;
      wr(ADDR_CTRL, ST | CO | (32'h1 << CTRL_WAITRD) | (32'h2 << CTRL_CH_LSB));
      poll(ADDR_STATUS, STAT_HOLD, 1'b1);
      n0 = nconv;
      repeat (40) @(posedge pclk);
      chk("hold_count", nconv - n0, 0);
      rd(ADDR_IRQ_STAT, 32'h0, 32'h2, 1'b0);
      rd(ADDR_RESULT, res(1'b0, 5'h02), RM, 1'b0);
      poll(ADDR_STATUS, STAT_HOLD, 1'b1);
      chk("resume", {31'h0, nconv > n0}, 32'h1);
      wr(ADDR_CTRL, 32'h1 << CTRL_STOP);
      slow <= 1'b0;
      poll(ADDR_STATUS, STAT_BUSY, 1'b0);
      // scan once over channels 2 and 7, done masked then unmasked
      wr(ADDR_CHSEL, 32'h84);
      wr(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_IRQ_STAT, 32'h0, 32'h0, 1'b0);
      n0 = nconv;
      wr(ADDR_CTRL, ST | SC);
      poll(ADDR_STATUS, STAT_BUSY, 1'b0);
      chk("scan_count", nconv - n0, 2);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      rd(ADDR_RESULT, res(1'b0, 5'h07), RM, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h1);
      wait_irq();
      rd(ADDR_IRQ_STAT, 32'h1, 32'h1, 1'b0);
      // scan continuous with an injected channel 9
      wr(ADDR_IRQ_MASK, 32'h4);
      wr(ADDR_CTRL, ST | CO | SC);
      poll(ADDR_STATUS, STAT_BUSY, 1'b1);
      wr(ADDR_CTRL, CO | SC | (32'h1 << CTRL_INJ) | (32'h9 << CTRL_INJCH_LSB));
      wait_irq();
      rd(ADDR_INJ, res(1'b0, 5'h09), 32'h3FF, 1'b0);
      n0 = n7;
      repeat (60) @(posedge pclk);
      chk("resume_scan", {31'h0, n7 > n0}, 32'h1);
      wr(ADDR_CTRL, 32'h1 << CTRL_STOP);
      poll(ADDR_STATUS, STAT_BUSY, 1'b0);
      // digital pins and an unmapped place
      g0 <= 16'($random(seed));
      g1 <= 16'($random(seed));
      @(posedge pclk);
      rd(ADDR_DIGIN, {g1, g0}, 32'hFFFF_FFFF, 1'b0);
      rd(8'h24, 32'h0, 32'hFFFF_FFFF, 1'b1);
      chk("cal_once", {31'h0, cal_run}, 32'h0);
      print_verdict();
   end
endmodule
